// *** logic/rpc_top.sv ***
// Calendar power control block with APB register front end
//
// How it works
// - Repeat: power on, settle, sample wakes, off
// - Sequence runs alone, host never woken
// - Runs only with the three enables set and the pin select on the switch code
// - Switch output polarity chosen by polarity bit
//
// The calendar delivers a one-cycle alarm pulse. When power control
// is active, the pulse powers the external device through the
// calendar pin, the block waits the settle time, gathers wake events
// over the sample window into sticky flags, then powers it down.
//
// Design decisions made here: the address map and the APB register port.
`default_nettype none
module rpc_top #(
    parameter int WAKE_W = 4,
    parameter int STABLE_DEF = rpc_pkg::STABLE_CYC,
    parameter int SAMPLE_DEF = rpc_pkg::SAMPLE_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Calendar alarm pulse, same clock
    input wire logic alarm_event,
    // Wake event pins of the external device
    input wire logic [WAKE_W-1:0] wake_in,
    // Calendar pin carrying the switch signal
    output logic external_power_switch_signal,
    output logic calendar_pin_oe
);
    import rpc_pkg::*;

    // Refuse shapes the logic cannot serve
    if (WAKE_W < 1 || WAKE_W > 16) begin : g_bad_wake
        $error("WAKE_W must lie in 1..16");
    end
    if (STABLE_DEF < 1 || STABLE_DEF >= (1 << CNT_W)) begin : g_bad_stable
        $error("STABLE_DEF out of counter range");
    end
    if (SAMPLE_DEF < 1 || SAMPLE_DEF >= (1 << CNT_W)) begin : g_bad_sample
        $error("SAMPLE_DEF out of counter range");
    end

    // Register reset values sized to the counters
    localparam logic [CNT_W-1:0] STABLE_RST = CNT_W'(STABLE_DEF);
    localparam logic [CNT_W-1:0] SAMPLE_RST = CNT_W'(SAMPLE_DEF);

    // Carrier to the sequencer
    rpc_seq_if #(.WAKE_W(WAKE_W)) sq ();

    // Software visible state
    logic [CTRL_W-1:0] ctrl;       // Enable, select and polarity bits
    logic [CNT_W-1:0] stable_cyc;  // Settle time in cycles
    logic [CNT_W-1:0] sample_cyc;  // Sample window in cycles
    logic [WAKE_W-1:0] wake_flag;  // Sticky sampled wake events
    logic [15:0] run_count;        // Completed sequences
    logic armed;                   // An alarm may launch a run

    // Wake pin synchronisers
    logic [WAKE_W-1:0] wake_meta;  // First stage, read by stage two only
    logic [WAKE_W-1:0] wake_sync;  // Second stage

    // Control field views
    wire cal_en = ctrl[CTRL_CAL_EN];
    wire pwc_en = ctrl[CTRL_PWC_EN];
    wire pin_oe = ctrl[CTRL_OE];
    wire [1:0] pin_sel = ctrl[CTRL_SEL +: 2];
    wire pol = ctrl[CTRL_POL];
    wire repeat_alarm_enable = ctrl[CTRL_REPEAT_ALARM_ENABLE];
    wire open_drain = ctrl[CTRL_OD];

    // Feature live only with calendar, power control and pin enables set and the pin select at SEL_PWC
    wire pwc_active = cal_en & pwc_en & pin_oe & (pin_sel == SEL_PWC);

    // APB phase decode
    wire apb_access = psel & penable;
    wire apb_commit = apb_access & pready;
    wire apb_wr = apb_commit & pwrite;

    // Address decode
    wire hit_ctrl = (paddr == OFS_CTRL);
    wire hit_stable = (paddr == OFS_STABLE);
    wire hit_sample = (paddr == OFS_SAMPLE);
    wire hit_status = (paddr == OFS_STATUS);
    wire hit_wake = (paddr == OFS_WAKE);
    wire hit_count = (paddr == OFS_COUNT);
    wire hit_any = hit_ctrl | hit_stable | hit_sample | hit_status | hit_wake | hit_count;
    wire bad_addr = ~hit_any | (paddr[1:0] != 2'h0);

    // Write strobes per register
    wire wr_ctrl = apb_wr & hit_ctrl;
    wire wr_stable = apb_wr & hit_stable;
    wire wr_sample = apb_wr & hit_sample;
    wire wr_wake = apb_wr & hit_wake;

    // Status word
    wire [31:0] status_word = {27'h0000000, pwc_active, armed,
                               sq.sampling, sq.pwr_on, sq.busy};

    // Read data mux
    wire [31:0] rd_mux =
        hit_ctrl ? {24'h000000, ctrl} :
        hit_stable ? {8'h00, stable_cyc} :
        hit_sample ? {8'h00, sample_cyc} :
        hit_status ? status_word :
        hit_wake ? {{(32 - WAKE_W){1'b0}}, wake_flag} :
        hit_count ? {16'h0000, run_count} :
        32'h00000000;

    // Sequencer hookup
    assign sq.start = pwc_active & armed & alarm_event & ~sq.busy;
    assign sq.abort = ~pwc_active;
    assign sq.stable_cyc = stable_cyc;
    assign sq.sample_cyc = sample_cyc;
    assign sq.wake = wake_sync;

    // Sticky wake flags: a new hit beats a write-one clear
    wire [WAKE_W-1:0] wake_clr = wr_wake ? pwdata[WAKE_W-1:0] : '0;
    wire [WAKE_W-1:0] next_wake_flag = (wake_flag & ~wake_clr) | sq.wake_hit;

    // Level of the switch signal for the chosen polarity
    wire pwr_req = sq.pwr_on & pwc_active;
    wire next_pin = pwr_req ? pol : ~pol;

    // Enable for push-pull or open-drain pin drive
    wire next_oe = open_drain ? (cal_en & pin_oe & ~next_pin) : (cal_en & pin_oe);

    // Sequencer instance
    rpc_seq u_seq (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sq(sq)
    );

    // Two-flop synchroniser on the wake pins
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wake_meta <= '0;
            wake_sync <= '0;
        end else begin
            wake_meta <= wake_in;
            wake_sync <= wake_meta;
        end
    end

    // APB handshake: one wait state, data and error from flops
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            // Raise ready in the second access cycle only
            pready <= apb_access & ~pready;
            pslverr <= apb_access & ~pready & bad_addr;
            // Capture read data ahead of ready
            if (apb_access & ~pready & ~pwrite & ~bad_addr) begin
                prdata <= rd_mux;
            end else if (apb_commit) begin
                prdata <= 32'h00000000;
            end
        end
    end

    // Control and timing registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl <= CTRL_RST;
            stable_cyc <= STABLE_RST;
            sample_cyc <= SAMPLE_RST;
        end else begin
            // Software steers the feature here
            if (wr_ctrl & ~bad_addr) begin
                ctrl <= pwdata[CTRL_W-1:0];
            end
            // Zero would skip the step; keep at least one cycle
            if (wr_stable) begin
                stable_cyc <= (pwdata[CNT_W-1:0] == '0) ? 24'h000001 : pwdata[CNT_W-1:0];
            end
            if (wr_sample) begin
                sample_cyc <= (pwdata[CNT_W-1:0] == '0) ? 24'h000001 : pwdata[CNT_W-1:0];
            end
        end
    end

    // Arming: one run per control write unless repeat is on
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            armed <= 1'b0;
        end else if (wr_ctrl) begin
            // Control write re-arms the alarm
            armed <= 1'b1;
        end else if (sq.done & ~repeat_alarm_enable) begin
            // Without repeat only one run happens
            armed <= 1'b0;
        end
    end

    // Wake flags and run counter, kept by hardware; the host can only clear flags by write-one
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wake_flag <= '0;
            run_count <= 16'h0000;
        end else begin
            // Flags gathered without any host action
            wake_flag <= next_wake_flag;
            if (sq.done) begin
                run_count <= run_count + 16'h0001;
            end
        end
    end

    // Calendar pin drive, inactive level while idle or disabled
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            external_power_switch_signal <= 1'b1;
            calendar_pin_oe <= 1'b0;
        end else begin
            external_power_switch_signal <= next_pin;
            calendar_pin_oe <= next_oe;
        end
    end
endmodule
`default_nettype wire

// *** inc/rpc_pkg.sv ***
// Constants and types shared by the calendar power control block
`default_nettype none
package rpc_pkg;
    // Clock period of sys_clk in ns
    localparam int CLK_NS = 10;
    // Default time the external device needs to settle, in us
    localparam int STABLE_US = 100;
    // Least settle time, rounded up to whole cycles
    localparam int STABLE_CYC = (STABLE_US * 1000 + CLK_NS - 1) / CLK_NS;
    // Default window for sampling wake events, in us
    localparam int SAMPLE_US = 10;
    // Longest sample window, rounded down to whole cycles
    localparam int SAMPLE_CYC = (SAMPLE_US * 1000) / CLK_NS;
    // Width of the settle and sample counters
    localparam int CNT_W = 24;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STABLE = 8'h04;
    localparam logic [7:0] OFS_SAMPLE = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_WAKE = 8'h10;
    localparam logic [7:0] OFS_COUNT = 8'h14;
    // Control register field positions
    localparam int CTRL_CAL_EN = 0;
    localparam int CTRL_PWC_EN = 1;
    localparam int CTRL_OE = 2;
    localparam int CTRL_SEL = 3;
    localparam int CTRL_POL = 5;
    localparam int CTRL_REPEAT_ALARM_ENABLE = 6;
    localparam int CTRL_OD = 7;
    localparam int CTRL_W = 8;
    // Pin select code that routes the switch signal to the pin
    localparam logic [1:0] SEL_PWC = 2'h3;
    // Control register reset value
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    // Status register field positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_PWR = 1;
    localparam int STAT_SAMP = 2;
    localparam int STAT_ARMED = 3;
    localparam int STAT_ACTIVE = 4;
    // Sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_SAMPLE, ST_OFF} rpc_state_t;
endpackage
`default_nettype wire

// *** inc/rpc_seq_if.sv ***
// Carrier between the register front end and the power sequencer
`default_nettype none
interface rpc_seq_if #(parameter int WAKE_W = 4);
    import rpc_pkg::*;
    logic start;                  // Alarm event that launches a sequence
    logic abort;                  // Feature switched off mid sequence
    logic [CNT_W-1:0] stable_cyc; // Settle time in cycles
    logic [CNT_W-1:0] sample_cyc; // Sample window in cycles
    logic [WAKE_W-1:0] wake;      // Synchronised wake event inputs
    logic busy;                   // A sequence is under way
    logic pwr_on;                 // External device power requested
    logic sampling;               // Wake events are being sampled
    logic done;                   // One-cycle pulse at sequence end
    logic [WAKE_W-1:0] wake_hit;  // Wake events seen while sampling
    // Sequencer end
    modport seq (input start, abort, stable_cyc, sample_cyc, wake,
                 output busy, pwr_on, sampling, done, wake_hit);
    // Register front end
    modport ctl (output start, abort, stable_cyc, sample_cyc, wake,
                 input busy, pwr_on, sampling, done, wake_hit);
endinterface
`default_nettype wire

// *** logic/rpc_seq.sv ***
// Power on, settle, sample and power off sequencer
`default_nettype none
module rpc_seq (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link to the front end
    rpc_seq_if.seq sq
);
    import rpc_pkg::*;

    rpc_state_t state;       // Current step of the sequence
    logic [CNT_W-1:0] cnt;   // Remaining cycles in this step
    logic cnt_zero;          // Step time has run out

    assign cnt_zero = (cnt <= 24'h000001);
    // Wake events count only inside the sample window
    assign sq.wake_hit = sq.sampling ? sq.wake : '0;

    // Step through on, settle, sample, off
    always_ff @(posedge sys_clk) begin
        sq.done <= 1'b0;
        if (!rst_n) begin
            state <= ST_IDLE;
            cnt <= '0;
            sq.busy <= 1'b0;
            sq.pwr_on <= 1'b0;
            sq.sampling <= 1'b0;
        end else if (sq.abort) begin
            // Feature off: drop power at once
            state <= ST_IDLE;
            sq.busy <= 1'b0;
            sq.pwr_on <= 1'b0;
            sq.sampling <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // Each run begins on an alarm event
                    if (sq.start) begin
                        state <= ST_SETTLE;
                        cnt <= sq.stable_cyc;
                        sq.busy <= 1'b1;
                        sq.pwr_on <= 1'b1;
                    end
                end
                ST_SETTLE: begin
                    // Wait for the device to become stable
                    cnt <= cnt - 24'h000001;
                    if (cnt_zero) begin
                        state <= ST_SAMPLE;
                        cnt <= sq.sample_cyc;
                        sq.sampling <= 1'b1;
                    end
                end
                ST_SAMPLE: begin
                    // Look at wake events for the window
                    cnt <= cnt - 24'h000001;
                    if (cnt_zero) begin
                        state <= ST_OFF;
                        sq.sampling <= 1'b0;
                        sq.pwr_on <= 1'b0;
                    end
                end
                ST_OFF: begin
                    // Power is off; report the end
                    state <= ST_IDLE;
                    sq.busy <= 1'b0;
                    sq.done <= 1'b1;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** verification/rpc_sva.sv ***
// Port assertions for the calendar power control block
`default_nettype none
module rpc_sva #(parameter int STABLE_DEF = 4, parameter int SAMPLE_DEF = 3) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Alarm and pin
    input wire logic alarm_event,
    input wire logic external_power_switch_signal,
    input wire logic calendar_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ctrl_q; // Shadow of the control register
    logic [23:0] stb_q; // Shadow of the settle time
    logic [23:0] smp_q; // Shadow of the sample window
    logic [24:0] on_cnt; // Cycles the pin has been active
    // Write that the slave takes at this edge
    wire wr_done = psel && penable && pready && pwrite;
    wire pol = ctrl_q[5];
    wire on = external_power_switch_signal == pol;
    wire act = ctrl_q[0] & ctrl_q[1] & ctrl_q[2] & (ctrl_q[4:3] == 2'h3);
    // Follow committed control writes and time the active level
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_q <= 8'h00;
            stb_q <= 24'(STABLE_DEF);
            smp_q <= 24'(SAMPLE_DEF);
            on_cnt <= 25'h0000000;
        end else begin
            if (wr_done && paddr == 8'h00) begin
                ctrl_q <= pwdata[7:0];
            end
            // Software may retime a run; zero is held as one cycle
            if (wr_done && paddr == 8'h04) begin
                stb_q <= (pwdata[23:0] == 24'h000000) ? 24'h000001 : pwdata[23:0];
            end
            if (wr_done && paddr == 8'h08) begin
                smp_q <= (pwdata[23:0] == 24'h000000) ? 24'h000001 : pwdata[23:0];
            end
            on_cnt <= on ? on_cnt + 25'h0000001 : 25'h0000000;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Pin turns active with control settled
    sequence s_rise;
        on && !$past(on) && $stable(ctrl_q);
    endsequence
    a_pready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("wait state wrong");
    a_ready_access: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("ready outside access");
    a_err_decode: assert property (pready |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'h0))
        else $error("error flag decode wrong");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0) else $error("error carries data");
    a_alarm_start: assert property (s_rise |-> $past(alarm_event, 2)) else $error("run without alarm");
    a_idle_inactive: assert property ((!act && $stable(ctrl_q)) [*3] |-> !on)
        else $error("pin active while gated");
    a_on_bound: assert property (on_cnt <= {1'b0, stb_q} + {1'b0, smp_q} + 25'h0000001)
        else $error("power held too long");
    a_oe_drive: assert property (act && !ctrl_q[7] && $past(act) && $past(act, 2) |-> calendar_pin_oe)
        else $error("pin not driven");
    a_od_low: assert property (ctrl_q[7] && $past(ctrl_q[7]) && calendar_pin_oe
        |-> !external_power_switch_signal) else $error("open drain drove high");
endmodule
bind rpc_top rpc_sva #(.STABLE_DEF(STABLE_DEF), .SAMPLE_DEF(SAMPLE_DEF)) sva_u (.sys_clk(sys_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .alarm_event(alarm_event),
    .external_power_switch_signal(external_power_switch_signal), .calendar_pin_oe(calendar_pin_oe));
`default_nettype wire

// *** verification/rpc_dev_model.sv ***
// External device powered through the calendar pin
`default_nettype none
module rpc_dev_model #(parameter int WAKE_W = 4, parameter logic PULL = 1'b1) (
    // Switch level, its drive enable and the polarity that means on
    input wire logic pwr_sw,
    input wire logic pwr_sw_oe,
    input wire logic pol,
    // Wake pattern raised while powered
    input wire logic [WAKE_W-1:0] wake_pat,
    // Wake lines, pulled down while unpowered
    output logic [WAKE_W-1:0] wake
);
    timeunit 1ns;
    timeprecision 1ps;
    // Undriven switch line rests at the external pull level
    wire sw_level = pwr_sw_oe ? pwr_sw : PULL;
    // Unpowered device leaves the pull-downs in charge
    assign wake = (sw_level == pol) ? wake_pat : '0;
endmodule
`default_nettype wire

// *** verification/rpc_top_tb_top.sv ***
// Self-checking bench for the calendar power control block
`default_nettype none
module rpc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rpc_pkg::*;
    localparam int SD = 4; // Short settle
    localparam int SM = 3; // Short sample
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic alarm_event = 1'b0;
    logic [3:0] wake_in;
    logic pin;
    logic pin_oe;
    logic pol_q = 1'b0; // Polarity last written
    int fail_count = 0;
    int compares = 0;
    int runs = 0; // Completed runs expected
    logic [31:0] rd;
    logic err;
    always #5 sys_clk = ~sys_clk;
    rpc_top #(.WAKE_W(4), .STABLE_DEF(SD), .SAMPLE_DEF(SM)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .alarm_event(alarm_event), .wake_in(wake_in),
        .external_power_switch_signal(pin), .calendar_pin_oe(pin_oe));
    rpc_dev_model #(.WAKE_W(4), .PULL(1'b1)) dev_u (.pwr_sw(pin), .pwr_sw_oe(pin_oe), .pol(pol_q),
        .wake_pat(4'hA), .wake(wake_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // One APB transfer, held until ready is sampled
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            chk(32'h0, 32'h1, "bus timeout");
            wrap_up();
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "read data");
        chk({31'h0, err}, {31'h0, exp_err}, "slave error");
    endtask
    // Alarm pulse, then active cycles counted over a window
    task automatic run_len(output int len);
        len = 0;
        @(posedge sys_clk);
        alarm_event <= 1'b1;
        @(posedge sys_clk);
        alarm_event <= 1'b0;
        repeat (30) begin
            @(posedge sys_clk);
            if (pin === pol_q) len++;
        end
    endtask
    task automatic t_reset();
        chk({30'h0, pin, pin_oe}, 32'h2, "idle pin");
        rdchk(OFS_CTRL, 32'h0, 1'b0);
        rdchk(OFS_STABLE, 32'(SD), 1'b0);
        rdchk(OFS_SAMPLE, 32'(SM), 1'b0);
        rdchk(8'h18, 32'h0, 1'b1);
        rdchk(8'h02, 32'h0, 1'b1);
        apb(1'b1, OFS_STABLE, 32'h0);
        rdchk(OFS_STABLE, 32'h1, 1'b0);
        apb(1'b1, OFS_STABLE, 32'(SD));
        $display("test reset done");
    endtask
    // Each missing enable keeps the pin at the inactive level
    task automatic t_gate();
        logic [7:0] cfg [4] = '{8'h7E, 8'h7D, 8'h7B, 8'h77};
        int len;
        pol_q <= 1'b1;
        foreach (cfg[i]) begin
            apb(1'b1, OFS_CTRL, {24'h0, cfg[i]});
            run_len(len);
            chk(32'(len), 32'h0, "gated run");
        end
        $display("test gate done");
    endtask
    task automatic t_run(input logic p, input logic rep);
        int len;
        pol_q <= p;
        apb(1'b1, OFS_CTRL, {24'h0, 1'b0, rep, p, 5'h1F});
        run_len(len);
        chk(32'(len >= SD + SM && len <= SD + SM + 1), 32'h1, "active time");
        run_len(len);
        chk(32'(len), rep ? 32'(SD + SM) : 32'h0, "one shot");
        chk(32'(len > 0), {31'h0, rep}, "repeat");
        runs += rep ? 2 : 1;
        rdchk(OFS_COUNT, 32'(runs), 1'b0);
        rdchk(OFS_WAKE, 32'hA, 1'b0);
        apb(1'b1, OFS_WAKE, 32'hF);
        rdchk(OFS_WAKE, 32'h0, 1'b0);
        $display("test run done");
    endtask
    // Open-drain active-low run; disable in mid-run drops power early
    task automatic t_abort();
        pol_q <= 1'b0;
        apb(1'b1, OFS_STABLE, 32'h40);
        apb(1'b1, OFS_CTRL, 32'hDF);
        @(posedge sys_clk);
        alarm_event <= 1'b1;
        @(posedge sys_clk);
        alarm_event <= 1'b0;
        chk({30'h0, pin, pin_oe}, 32'h2, "released");
        repeat (3) @(posedge sys_clk);
        chk({30'h0, pin, pin_oe}, 32'h1, "powered");
        rdchk(OFS_STATUS, 32'h1B, 1'b0);
        apb(1'b1, OFS_CTRL, 32'hDD);
        repeat (2) @(posedge sys_clk);
        chk({30'h0, pin, pin_oe}, 32'h2, "abort");
        rdchk(OFS_STATUS, 32'h08, 1'b0);
        rdchk(OFS_COUNT, 32'(runs), 1'b0);
        $display("test abort done");
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_gate();
        t_run(1'b0, 1'b1);
        t_run(1'b1, 1'b1);
        t_run(1'b0, 1'b0);
        t_abort();
        wrap_up();
    end
endmodule
`default_nettype wire
